// ===== verilog/vps_pkg.sv
// Constants, enumerations and carriers of the PCM voice slot port
// Assumes users import the whole package
package vps_pkg;

   // ***************************************************
   // Register offsets (byte addresses, one word each)
   // ***************************************************
   localparam logic [7:0] VPS_OFF_VOICE = 8'h00;
   localparam logic [7:0] VPS_OFF_PCMIF = 8'h04;
   localparam logic [7:0] VPS_OFF_FMT   = 8'h08;
   localparam logic [7:0] VPS_OFF_NOISE = 8'h0c;
   localparam logic [7:0] VPS_OFF_SLOT  = 8'h10;
   localparam logic [7:0] VPS_OFF_CONN  = 8'h14;
   localparam logic [7:0] VPS_OFF_STAT  = 8'h18;

   // ***************************************************
   // Field positions and counts
   // ***************************************************
   localparam int VPS_CONN_ADD_BIT = 0;
   localparam int VPS_CONN_DEL_POS = 8;
   localparam int VPS_NCONN_DEF    = 2;
   localparam int VPS_SLOT_BITS    = 16;

   // ***************************************************
   // Modes
   // ***************************************************
   // Air side: linear code is the CVSD path, carried as linear samples
   typedef enum logic [1:0] {
      VPS_CODE_LIN  = 2'h0,
      VPS_CODE_ALAW = 2'h1,
      VPS_CODE_ULAW = 2'h2
   } vps_coding_e;

   typedef enum logic [1:0] {
      VPS_FILL_ZERO = 2'h0,
      VPS_FILL_ONE  = 2'h1,
      VPS_FILL_SIGN = 2'h2
   } vps_fill_e;

   typedef enum logic [1:0] {
      VPS_CN_SILENCE = 2'h0,
      VPS_CN_REPEAT  = 2'h1,
      VPS_CN_NOISE   = 2'h2
   } vps_noise_e;

   // Bit clock rate; an 8 kHz frame then holds 1, 2, 4 or 8 slots
   typedef enum logic [1:0] {
      VPS_RATE_128K  = 2'h0,
      VPS_RATE_256K  = 2'h1,
      VPS_RATE_512K  = 2'h2,
      VPS_RATE_1024K = 2'h3
   } vps_rate_e;

   // ***************************************************
   // Carriers
   // ***************************************************
   typedef struct packed {
      vps_coding_e air_coding;
      vps_coding_e in_coding;
   } vps_voice_s;

   typedef struct packed {
      logic      master;
      logic      long_sync;
      vps_rate_e rate;
   } vps_pcmif_s;

   typedef struct packed {
      logic      lsb_first;
      logic      right_just;
      logic [1:0] fill_cnt;
      vps_fill_e fill_mode;
   } vps_fmt_s;

   typedef struct packed {
      logic        lost;
      logic [15:0] data;
   } vps_air_s;

   // ***************************************************
   // Reset values and coding constants
   // ***************************************************
   localparam vps_voice_s VPS_VOICE_RST = '{air_coding: VPS_CODE_LIN, in_coding: VPS_CODE_LIN};
   localparam vps_pcmif_s VPS_PCMIF_RST = '{master: 1'b1, long_sync: 1'b0, rate: VPS_RATE_512K};
   localparam vps_fmt_s   VPS_FMT_RST   = '{lsb_first: 1'b0, right_just: 1'b0, fill_cnt: 2'h0,
                                            fill_mode: VPS_FILL_ZERO};
   localparam logic [15:0] VPS_LFSR_SEED = 16'hace1;
   localparam logic [7:0]  VPS_A_XOR     = 8'h55;
   localparam logic [15:0] VPS_U_BIAS    = 16'h0084;
   localparam logic [15:0] VPS_U_CLIP    = 16'h1fde;
   localparam logic [15:0] VPS_A_CLIP    = 16'h0fff;

endpackage : vps_pkg

// ===== verilog/vps_pcm_port.sv
// PCM voice slot port: APB registers, sample coding and slot engine
// Assumes pcm_bclk is the free running bit clock, pins timed to it
// Operation
// - Port samples are 16-bit linear or 8-bit A-law/mu-law, by setting
// - Companded byte sits right or left in the 16-bit slot
// - Companded slot shifts LSB first or MSB first, by setting
// - Each slot is 16 bit clocks; linear audio keeps 13 bits
// - Linear sample padded to 14, 15 or 16 bits, left or right justified
// - Each fill bit is 1, 0 or the sign bit
// - Fill positions follow fill count and justification, never overlapping data
// - Linear slot shifts LSB first or MSB first, by setting
// - Slots are counted after each frame sync
// - Master at 512 kHz with short sync gives slots 0 to 3
// - Serial output released in slots without an active connection
// - Added connections exchange samples through the port automatically
// - Master or slave role, bit clock rate and sync type are settable
// - Slot select sets the next connection's slot; active ones keep theirs
// - Lost air samples replaced by the comfort noise policy
// - Fill of linear format ignored for companded data; justification still places the byte
// - Converts port format to air coding CVSD, A-law or mu-law
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/1ps
module vps_pcm_port
   import vps_pkg::*;
#(
   parameter int NCONN = VPS_NCONN_DEF
) (
   input  wire  logic                         pclk,
   input  wire  logic                         presetn,
   input  wire  logic                         pce,
   input  wire  logic                         psel,
   input  wire  logic                         penable,
   input  wire  logic                         pwrite,
   input  wire  logic [7:0]                   paddr,
   input  wire  logic [31:0]                  pwdata,
   output logic       [31:0]                  prdata,
   output logic                               pready,
   output logic                               pslverr,
   input  wire  logic                         pcm_bclk,
   input  wire  logic                         pcm_din,
   output logic                               pcm_dout,
   output logic                               pcm_dout_oe,
   input  wire  logic                         pcm_sync_i,
   output logic                               pcm_sync_o,
   output logic                               pcm_sync_oe,
   input  wire  logic [NCONN-1:0]             air_tx_valid,
   input  wire  vps_air_s [NCONN-1:0]         air_tx,
   output logic       [NCONN-1:0]             air_rx_valid,
   output logic       [NCONN-1:0][15:0]       air_rx_data
);

   localparam int LCW = 5 + NCONN * 4;

   vps_voice_s               voice_q;
   vps_pcmif_s               pcmif_q;
   vps_fmt_s                 fmt_q;
   vps_noise_e               noise_q;
   logic [2:0]               slot_sel_q;
   logic [NCONN-1:0]         act_q;
   logic [NCONN-1:0][2:0]    slot_q;
   logic                     ld_q;
   logic [31:0]              prdata_q;
   logic                     pslverr_q;
   logic [15:0]              lfsr_q;
   logic [NCONN-1:0][15:0]   tx_w_q;
   logic [NCONN-1:0][15:0]   last_q;
   logic [NCONN-1:0][15:0]   air_rx_data_q;
   logic [NCONN-1:0]         air_rx_valid_q;
   logic [NCONN-1:0][2:0]    ds_q;
   logic [NCONN-1:0][15:0]   tx_lin;
   logic [NCONN-1:0]         evt;
   logic [1:0]               lrst_q;
   logic                     lrst_n;
   logic [LCW-1:0]           lcfg_m_q;
   logic [LCW-1:0]           lcfg_q;
   logic                     lce;
   vps_pcmif_s               lpcm;
   logic [NCONN-1:0]         lact;
   logic [NCONN-1:0][2:0]    lslot;
   logic                     din_n_q;
   logic                     sync_n_q;
   logic                     sync_old_q;
   logic                     sync_o_q;
   logic                     dout_q;
   logic                     oe_q;
   logic [7:0]               pos_q;
   logic [7:0]               pos_d;
   logic [15:0]              sh_q;
   logic [15:0]              rsh_q;
   logic [15:0]              tx_sel;
   logic [NCONN-1:0][15:0]   rx_hold_q;
   logic [NCONN-1:0]         done_t_q;
   logic [NCONN-1:0]         hit_d;
   logic [NCONN-1:0]         hit_c;

   // ***************************************************
   // Sample coding
   // ***************************************************
   function automatic logic [15:0] abs16(input logic [15:0] s);
      return s[15] ? 16'(-s) : s;
   endfunction : abs16

   function automatic logic [7:0] ulaw_enc(input logic [15:0] s);
      logic [15:0] m;
      logic [2:0]  e;
      m = abs16(s) >> 2;
      if (m > VPS_U_CLIP) begin
         m = VPS_U_CLIP;
      end
      m = m + 16'd33;
      e = 3'h0;
      for (int i = 6; i <= 12; i++) begin
         if (m[i]) begin
            e = 3'(i - 5);
         end
      end
      return ~{s[15], e, 4'(m >> (4'(e) + 4'h1))};
   endfunction : ulaw_enc

   function automatic logic [15:0] ulaw_dec(input logic [7:0] c);
      logic [7:0]  u;
      logic [15:0] m;
      u = ~c;
      m = ((16'({u[3:0], 3'b000}) + VPS_U_BIAS) << u[6:4]) - VPS_U_BIAS;
      return u[7] ? 16'(-m) : m;
   endfunction : ulaw_dec

   function automatic logic [7:0] alaw_enc(input logic [15:0] s);
      logic [15:0] m;
      logic [2:0]  e;
      logic [3:0]  q;
      m = abs16(s) >> 3;
      if (m > VPS_A_CLIP) begin
         m = VPS_A_CLIP;
      end
      e = 3'h0;
      for (int i = 5; i <= 11; i++) begin
         if (m[i]) begin
            e = 3'(i - 4);
         end
      end
      q = (e == 3'h0) ? 4'(m >> 1) : 4'(m >> e);
      return {~s[15], e, q} ^ VPS_A_XOR;
   endfunction : alaw_enc

   function automatic logic [15:0] alaw_dec(input logic [7:0] c);
      logic [7:0]  a;
      logic [15:0] m;
      a = c ^ VPS_A_XOR;
      m = 16'({a[3:0], 4'h8});
      if (a[6:4] != 3'h0) begin
         m = (m + 16'h0100) << (a[6:4] - 3'h1);
      end
      return a[7] ? m : 16'(-m);
   endfunction : alaw_dec

   function automatic logic [15:0] to_lin(input vps_coding_e k, input logic [15:0] v);
      case (k)
         VPS_CODE_ALAW: return alaw_dec(v[7:0]);
         VPS_CODE_ULAW: return ulaw_dec(v[7:0]);
         default:       return v;
      endcase
   endfunction : to_lin

   function automatic logic [15:0] from_lin(input vps_coding_e k, input logic [15:0] v);
      case (k)
         VPS_CODE_ALAW: return {8'h00, alaw_enc(v)};
         VPS_CODE_ULAW: return {8'h00, ulaw_enc(v)};
         default:       return v;
      endcase
   endfunction : from_lin

   function automatic logic [15:0] rev16(input logic [15:0] v);
      logic [15:0] r;
      for (int i = 0; i < 16; i++) begin
         r[i] = v[15-i];
      end
      return r;
   endfunction : rev16

   // Slot word in send order: bit 15 leaves first
   function automatic logic [15:0] pack_port(input vps_voice_s vc, input vps_fmt_s f,
                                             input logic [15:0] lin);
      logic [15:0] w;
      logic [7:0]  c;
      logic        fb;
      c = 8'(from_lin(vc.in_coding, lin));
      fb = (f.fill_mode == VPS_FILL_ONE) | ((f.fill_mode == VPS_FILL_SIGN) & lin[15]);
      if (vc.in_coding != VPS_CODE_LIN) begin
         w = f.right_just ? {8'h00, c} : {c, 8'h00};
      end else begin
         w = {lin[15:3], {3{fb}}} & ~(16'h0007 >> f.fill_cnt);
         w = f.right_just ? w >> (2'd3 - f.fill_cnt) : w;
      end
      return f.lsb_first ? rev16(w) : w;
   endfunction : pack_port

   function automatic logic [15:0] unpack_port(input vps_voice_s vc, input vps_fmt_s f,
                                               input logic [15:0] r);
      logic [15:0] w;
      w = f.lsb_first ? rev16(r) : r;
      if (vc.in_coding != VPS_CODE_LIN) begin
         return to_lin(vc.in_coding, {8'h00, f.right_just ? w[7:0] : w[15:8]});
      end
      w = f.right_just ? w << (2'd3 - f.fill_cnt) : w;
      return {w[15:3], 3'b000};
   endfunction : unpack_port

   // ***************************************************
   // APB slave
   // ***************************************************
   logic        wr_go;
   logic        sel_voice;
   logic        sel_pcmif;
   logic        sel_fmt;
   logic        sel_noise;
   logic        sel_slot;
   logic        sel_conn;
   logic        sel_stat;
   logic        map_hit;
   logic [31:0] rd_mux;

   assign pready    = ld_q & pce;
   assign wr_go     = psel & penable & pwrite & pready;
   assign sel_voice = paddr == VPS_OFF_VOICE;
   assign sel_pcmif = paddr == VPS_OFF_PCMIF;
   assign sel_fmt   = paddr == VPS_OFF_FMT;
   assign sel_noise = paddr == VPS_OFF_NOISE;
   assign sel_slot  = paddr == VPS_OFF_SLOT;
   assign sel_conn  = paddr == VPS_OFF_CONN;
   assign sel_stat  = paddr == VPS_OFF_STAT;
   assign map_hit   = sel_voice | sel_pcmif | sel_fmt | sel_noise | sel_slot | sel_conn | sel_stat;
   assign rd_mux    = sel_voice ? 32'(voice_q) :
                      sel_pcmif ? 32'(pcmif_q) :
                      sel_fmt   ? 32'(fmt_q) :
                      sel_noise ? 32'(noise_q) :
                      sel_slot  ? 32'(slot_sel_q) :
                      sel_conn  ? 32'({act_q, 8'h00}) :
                      sel_stat  ? 32'(slot_q) : 32'h0000_0000;
   assign prdata    = prdata_q;
   assign pslverr   = pslverr_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ld_q      <= 1'b0;
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (pce) begin
         ld_q <= psel & ~(penable & ld_q);
         if (psel & ~ld_q) begin
            prdata_q  <= rd_mux;
            pslverr_q <= ~map_hit;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         voice_q    <= VPS_VOICE_RST;
         pcmif_q    <= VPS_PCMIF_RST;
         fmt_q      <= VPS_FMT_RST;
         noise_q    <= VPS_CN_SILENCE;
         slot_sel_q <= 3'h0;
      end else if (pce & wr_go) begin
         if (sel_voice) voice_q <= vps_voice_s'(pwdata[3:0]);
         if (sel_pcmif) pcmif_q <= vps_pcmif_s'(pwdata[3:0]);
         if (sel_fmt) fmt_q <= vps_fmt_s'(pwdata[5:0]);
         if (sel_noise) noise_q <= vps_noise_e'(pwdata[1:0]);
         if (sel_slot) slot_sel_q <= pwdata[2:0];
      end
   end

   // ***************************************************
   // Connection table
   // ***************************************************
   logic             add_go;
   logic [NCONN-1:0] del_m;
   logic [NCONN-1:0] free_oh;

   assign add_go  = wr_go & sel_conn & pwdata[VPS_CONN_ADD_BIT];
   assign del_m   = (wr_go & sel_conn) ? pwdata[VPS_CONN_DEL_POS +: NCONN] : '0;
   assign free_oh = ~act_q & NCONN'(act_q + NCONN'(1));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         act_q  <= '0;
         slot_q <= '0;
      end else if (pce) begin
         act_q <= (act_q & ~del_m) | (add_go ? free_oh : '0);
         for (int i = 0; i < NCONN; i++) begin
            if (add_go & free_oh[i]) slot_q[i] <= slot_sel_q;
         end
      end
   end

   // ***************************************************
   // Per connection sample exchange
   // ***************************************************
   for (genvar g = 0; g < NCONN; g++) begin : g_ch
      assign evt[g]    = ds_q[g][1] ^ ds_q[g][2];
      assign tx_lin[g] = (air_tx_valid[g] & ~air_tx[g].lost) ?
                         to_lin(voice_q.air_coding, air_tx[g].data) :
                         (noise_q == VPS_CN_REPEAT) ? last_q[g] :
                         (noise_q == VPS_CN_NOISE) ? {{8{lfsr_q[7]}}, lfsr_q[7:0]} : 16'h0000;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ds_q           <= '0;
         air_rx_valid_q <= '0;
         air_rx_data_q  <= '0;
         last_q         <= '0;
         tx_w_q         <= '0;
         lfsr_q         <= VPS_LFSR_SEED;
      end else if (pce) begin
         lfsr_q         <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
         air_rx_valid_q <= evt;
         for (int i = 0; i < NCONN; i++) begin
            ds_q[i] <= {ds_q[i][1:0], done_t_q[i]};
            if (evt[i]) begin
               air_rx_data_q[i] <= from_lin(voice_q.air_coding,
                                            unpack_port(voice_q, fmt_q, rx_hold_q[i]));
               last_q[i]        <= tx_lin[i];
               tx_w_q[i]        <= pack_port(voice_q, fmt_q, tx_lin[i]);
            end
         end
      end
   end

   assign air_rx_valid = air_rx_valid_q;
   assign air_rx_data  = air_rx_data_q;

   // ***************************************************
   // Link domain: reset, settings and pin capture
   // ***************************************************
   always_ff @(posedge pcm_bclk or negedge presetn) begin
      if (!presetn) lrst_q <= 2'b00;
      else lrst_q <= {lrst_q[0], 1'b1};
   end

   assign lrst_n = lrst_q[1];

   always_ff @(posedge pcm_bclk or negedge lrst_n) begin
      if (!lrst_n) begin
         lcfg_m_q <= '0;
         lcfg_q   <= '0;
      end else begin
         lcfg_m_q <= {pce, pcmif_q, act_q, slot_q};
         lcfg_q   <= lcfg_m_q;
      end
   end

   assign {lce, lpcm, lact, lslot} = lcfg_q;

   // Falling edge capture of data and sync
   always_ff @(negedge pcm_bclk or negedge lrst_n) begin
      if (!lrst_n) begin
         din_n_q  <= 1'b0;
         sync_n_q <= 1'b0;
      end else if (lce) begin
         din_n_q  <= pcm_din;
         sync_n_q <= pcm_sync_i;
      end
   end

   // ***************************************************
   // Link domain: slot engine
   // ***************************************************
   logic [3:0] last_slot;
   logic       sync_rise;
   logic       wrap;
   logic       sync_go;

   assign last_slot = 4'((5'h01 << lpcm.rate) - 5'h01);
   assign sync_rise = ~lpcm.master & sync_n_q & ~sync_old_q;
   assign wrap      = pos_q == {last_slot, 4'hf};
   assign pos_d     = sync_rise ? 8'h01 : wrap ? 8'h00 : 8'(pos_q + 8'h01);
   assign sync_go   = lpcm.master & (lpcm.long_sync ? pos_d[7:4] == 4'h0 : pos_d == 8'h00);

   for (genvar g = 0; g < NCONN; g++) begin : g_hit
      assign hit_d[g] = lact[g] & (pos_d[7:4] == {1'b0, lslot[g]});
      assign hit_c[g] = lact[g] & (pos_q[7:4] == {1'b0, lslot[g]});
   end

   always_comb begin
      tx_sel = 16'h0000;
      for (int i = 0; i < NCONN; i++) begin
         if (hit_d[i]) tx_sel = tx_sel | tx_w_q[i];
      end
   end

   always_ff @(posedge pcm_bclk or negedge lrst_n) begin
      if (!lrst_n) begin
         pos_q      <= 8'h00;
         sync_old_q <= 1'b0;
         sync_o_q   <= 1'b0;
         oe_q       <= 1'b0;
         dout_q     <= 1'b0;
         sh_q       <= 16'h0000;
         rsh_q      <= 16'h0000;
      end else if (lce) begin
         pos_q      <= pos_d;
         sync_old_q <= sync_n_q;
         sync_o_q   <= sync_go;
         oe_q       <= |hit_d;
         rsh_q      <= {rsh_q[14:0], din_n_q};
         if (pos_d[3:0] == 4'h0) begin
            dout_q <= tx_sel[15];
            sh_q   <= {tx_sel[14:0], 1'b0};
         end else begin
            dout_q <= sh_q[15];
            sh_q   <= {sh_q[14:0], 1'b0};
         end
      end
   end

   always_ff @(posedge pcm_bclk or negedge lrst_n) begin
      if (!lrst_n) begin
         rx_hold_q <= '0;
         done_t_q  <= '0;
      end else if (lce) begin
         for (int i = 0; i < NCONN; i++) begin
            if (pos_q[3:0] == 4'hf && hit_c[i]) begin
               rx_hold_q[i] <= {rsh_q[14:0], din_n_q};
               done_t_q[i]  <= ~done_t_q[i];
            end
         end
      end
   end

   assign pcm_dout    = dout_q;
   assign pcm_dout_oe = oe_q;
   assign pcm_sync_o  = sync_o_q;
   assign pcm_sync_oe = lpcm.master;

   // ***************************************************
   // Checks
   // ***************************************************
   AST_OE_SLOT:
   assert property (@(posedge pcm_bclk) disable iff (!lrst_n) (oe_q && $stable(lact)) |-> (|hit_c))
      else $error("Output driven in a slot without a connection");

   AST_SYNC_SHORT:
   assert property (@(posedge pcm_bclk) disable iff (!lrst_n)
      (sync_o_q && lce && !lpcm.long_sync && $stable(lpcm)) |=> !sync_o_q)
      else $error("Short frame sync lasted more than one bit clock");

   AST_SYNC_SLOT0:
   assert property (@(posedge pcm_bclk) disable iff (!lrst_n)
      (sync_o_q && !lpcm.long_sync) |-> pos_q == 8'h00)
      else $error("Frame sync not aligned to slot 0 bit 0");

   AST_SLOT_WIDTH:
   assert property (@(posedge pcm_bclk) disable iff (!lrst_n)
      (lce && lpcm.master && pos_q[3:0] == 4'hf) |=> pos_q[3:0] == 4'h0)
      else $error("Slot not 16 bit clocks long");

   AST_FOUR_SLOTS:
   assert property (@(posedge pcm_bclk) disable iff (!lrst_n)
      (lce && lpcm.master && lpcm.rate == VPS_RATE_512K && pos_q == 8'h3f) |=> pos_q == 8'h00)
      else $error("512 kHz master frame not four slots");

   AST_SLAVE_LOCK:
   assert property (@(posedge pcm_bclk) disable iff (!lrst_n)
      (lce && sync_rise) |=> pos_q == 8'h01)
      else $error("Slave counter not restarted by frame sync");

   AST_RX_DONE:
   assert property (@(posedge pcm_bclk) disable iff (!lrst_n)
      (lce && pos_q[3:0] == 4'hf && hit_c[0]) |=> done_t_q[0] != $past(done_t_q[0]))
      else $error("Received slot word not handed over");

   AST_ADD_CONN:
   assert property (@(posedge pclk) disable iff (!presetn)
      (pce && add_go && del_m == '0 && free_oh != '0) |=> $countones(act_q) == $past($countones(act_q)) + 1)
      else $error("Added connection not activated");

   AST_KEEP_SLOT:
   assert property (@(posedge pclk) disable iff (!presetn)
      ($past(act_q[0]) && act_q[0]) |-> $stable(slot_q[0]))
      else $error("Active connection moved to another slot");

   COV_TWO_CONN: cover property (@(posedge pclk) disable iff (!presetn) act_q[0] && act_q[NCONN-1]);
   COV_RX_EVT: cover property (@(posedge pclk) disable iff (!presetn) evt[0] && !air_tx_valid[0]);
   COV_SLAVE: cover property (@(posedge pcm_bclk) disable iff (!lrst_n) sync_rise ##16 oe_q);

endmodule : vps_pcm_port

// ===== sim/vps_codec.sv
// Codec model sharing the PCM bus in one slot
// Assumes 64-bit frame, sync from whichever side is master, slot word MSB first
`timescale 1ns/1ps
module vps_codec #(parameter int SLOT = 2) (
   input  wire logic        bclk,
   input  wire logic        sync,
   input  wire logic        dout,
   input  wire logic        dout_oe,
   input  wire logic [15:0] tx_word,
   output logic             din,
   output logic [15:0]      rx_word,
   output int               oe_bad
);
   int          pos = 0;
   int          lk  = 0;
   logic [15:0] sh = '0;
   initial begin
      din = 1'b0;
      rx_word = '0;
      oe_bad = 0;
   end
   // Sample on falling edge; frame length checked once a sync was seen
   always @(negedge bclk) begin
      pos = sync ? 0 : (pos + 1) % 64;
      if (sync) lk = 1;
      if (lk != 0 && !sync && pos == 0) oe_bad = oe_bad + 1;
      if (dout_oe === 1'b1 && pos / 16 != SLOT) oe_bad = oe_bad + 1;
      // A released line reads as the inverse of its stale bit
      if (pos / 16 == SLOT) sh = {sh[14:0], (dout_oe === 1'b1) ? dout : ~dout};
      if (pos == 16 * SLOT + 15) rx_word = sh;
   end
   // Next bit launched on the rising edge, half a bit before it is sampled
   always @(posedge bclk) begin
      // Outside the slot the line toggles so stale data never looks valid
      din <= (((pos + 1) % 64) / 16 == SLOT) ? tx_word[15 - (pos + 1) % 16] : ~din;
   end
endmodule : vps_codec

// ===== sim/tb_top.sv
// Self-checking bench of the PCM voice slot port
// Assumes the codec model in slot 2 of a 512k frame, port master then slave
`timescale 1ns/1ps
module tb_top;
   import vps_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic pcm_bclk, pcm_din, pcm_dout, pcm_dout_oe, pcm_sync_o, pcm_sync_oe;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0] air_tx_valid, air_rx_valid;
   vps_air_s [1:0] air_tx;
   logic [1:0][15:0] air_rx_data;
   logic [15:0] cw, cr, d;
   int bad, err_count, checks, s0, sc, nrx, nrx1;
   logic slv;
   logic sync_i = 1'b0;
   vps_pcm_port vps_pcm_port_i (.pce(1'b1), .pcm_sync_i(sync_i), .*);
   vps_codec vps_codec_i (.bclk(pcm_bclk), .sync(pcm_sync_oe ? pcm_sync_o : sync_i), .dout(pcm_dout),
                          .dout_oe(pcm_dout_oe),
                          .tx_word(cw), .din(pcm_din), .rx_word(cr), .oe_bad(bad));
   initial begin
      pclk = 0;
      forever #20 pclk = ~pclk;
   end
   initial begin
      pcm_bclk = 0;
      #1.7;
      forever #3 pcm_bclk = ~pcm_bclk;
   end
   // Slave frame sync, kept in step with the port's own master frame
   always @(posedge pcm_bclk) begin
      sc = pcm_sync_o ? 1 : (sc + 1) % 64;
      sync_i <= slv && sc == 0;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // One APB transfer, entered and left just after a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      @(posedge pclk);
      penable <= 1'b1;
      do @(negedge pclk); while (pready !== 1'b1);
      @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   // Linear slot word: 13 bits on top, three fill bits of one when lsb
   function automatic logic [15:0] fmtw(logic [15:0] s, int lsb);
      logic [15:0] w;
      w = lsb ? {s[15:3], 3'b111} : {s[15:3], 3'b000};
      return lsb ? rv(w) : w;
   endfunction : fmtw
   function automatic logic [15:0] rv(input logic [15:0] v);
      logic [15:0] r;
      for (int i = 0; i < 16; i++) r[i] = v[15 - i];
      return r;
   endfunction : rv
   // Wait 80 cycles, counting hand-over pulses of both channels
   task automatic wt();
      nrx = 0;
      nrx1 = 0;
      repeat (80) begin
         @(negedge pclk);
         nrx += air_rx_valid[0];
         nrx1 += air_rx_valid[1];
      end
      @(posedge pclk);
   endtask : wt
   task automatic end_of_test();
      $display("err_count %0d checks %0d", err_count, checks);
      if (err_count == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_of_test
   initial begin
      #200000;
      err_count++;
      end_of_test();
   end
   initial begin
      s0 = $urandom(90078);
      {presetn, psel, penable, pwrite, paddr, pwdata, air_tx_valid, air_tx, cw, slv} = '0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(0, VPS_OFF_PCMIF, 0); chk(rd, 32'ha);
      apb(1, 8'h40, 5); chk({er, rd[30:0]}, 32'h80000000);
      apb(1, VPS_OFF_SLOT, 2);
      for (int k = 0; k < 3; k++) begin
         apb(1, VPS_OFF_CONN, 32'h100);
         if (k == 2) begin
            // Slave from here on, bench sync in the old frame phase
            slv <= 1'b1;
            apb(1, VPS_OFF_PCMIF, 2);
            wt();
         end
         apb(1, VPS_OFF_FMT, k > 0 ? 32'h2d : 0);
         d = 16'($urandom);
         air_tx_valid <= 2'b01;
         air_tx[0] <= {1'b0, d};
         cw <= 16'($urandom);
         apb(1, VPS_OFF_CONN, 1);
         apb(0, VPS_OFF_CONN, 0); chk(rd, 32'h100);
         apb(0, VPS_OFF_STAT, 0); chk(rd[2:0], 3'h2);
         wt();
         chk(cr, fmtw(d, k > 0));
         chk(air_rx_data[0], (k > 0 ? rv(cw) : cw) & 16'hfff8);
         chk(nrx >= 8 && nrx <= 9 && nrx1 == 0, 1);
         chk(pcm_sync_oe, k < 2);
         chk(bad, 0);
      end
      apb(1, VPS_OFF_NOISE, 1);
      air_tx[0] <= {1'b1, d};
      wt();
      chk(cr, fmtw(d, 1));
      apb(1, VPS_OFF_NOISE, 0);
      wt();
      chk(cr, fmtw(16'h0000, 1));
      chk(bad, 0);
      end_of_test();
   end
endmodule : tb_top
